/* hdl/slf_pkg.sv */
// Shared constants, field layout and line-code tables for the serial link word framer
package slf_pkg;

    // ********************************************************************
    // Clock and timing
    // ********************************************************************
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned REV_POWERUP_US  = 500;
    localparam int unsigned REV_POWERUP_CYC = REV_POWERUP_US * CLK_MHZ;
    localparam int unsigned REV_BLANK_US    = 350;
    localparam int unsigned REV_BLANK_CYC   = REV_BLANK_US * CLK_MHZ;
    localparam int unsigned CNT_W           = 17;

    // ********************************************************************
    // Word layout
    // ********************************************************************
    localparam int unsigned DATA_PINS     = 29;
    localparam int unsigned NARROW_DATA   = 21;
    localparam int unsigned WIDE_DATA     = 29;
    localparam int unsigned NARROW_AUD    = 21;
    localparam int unsigned NARROW_FWD    = 22;
    localparam int unsigned NARROW_PAR    = 23;
    localparam int unsigned WIDE_AUD      = 29;
    localparam int unsigned WIDE_FWD      = 30;
    localparam int unsigned WIDE_PAR      = 31;
    localparam int unsigned WORD_BITS     = 32;
    localparam int unsigned LANES         = 4;
    localparam int unsigned SYM_BITS      = 10;
    localparam int unsigned BYTE_BITS     = 8;

    // ********************************************************************
    // Pin synchroniser slots
    // ********************************************************************
    localparam int unsigned SYN_WID  = 0;
    localparam int unsigned SYN_SD   = 1;
    localparam int unsigned SYN_SCK  = 2;
    localparam int unsigned SYN_WS   = 3;
    localparam int unsigned SYN_FWD  = 4;
    localparam int unsigned SYN_RCTL = 5;
    localparam int unsigned SYN_RINT = 6;
    localparam int unsigned SYN_FDX  = 7;
    localparam int unsigned SYN_N    = 8;

    // ********************************************************************
    // Reset values, scrambler and audio slot phases
    // ********************************************************************
    localparam logic [7:0]  SER_ADDR_RST = 8'h80;
    localparam logic [7:0]  DES_ADDR_RST = 8'h90;
    localparam logic [31:0] SCR_SEED     = 32'hFFFFFFFF;
    localparam logic [31:0] SCR_POLY     = 32'h80200003;
    localparam logic        UART_IDLE    = 1'b1;

    typedef enum logic [1:0] {
        PH_SD  = 2'b00,
        PH_SCK = 2'b01,
        PH_WS  = 2'b10
    } slf_aud_phase_t;

    // ********************************************************************
    // 8B/10B tables, negative running disparity codes
    // ********************************************************************
    localparam logic [5:0] SLF_T6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] SLF_T4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [4:0] D6_FLIP = 5'h07;
    localparam logic [2:0] D4_FLIP = 3'h3;

endpackage

/* hdl/slf_word_framer.sv */
// Serial link word framer: word assembly, scrambling, line coding and reverse path gating
//
// How it works
// - Width select pin low gives 24-bit bus, high gives 32-bit bus.
// - Narrow mode ignores data bits 21 to 28 and forces them low.
// - Audio pins have their own ports; only the serial-data pin acts as data, and only with audio disabled.
// - Audio disabled: serial-data audio pin rides in the audio slot as data.
// - Each data bit leaves and arrives at the same bit position.
// - Assembled words are scrambled, then 8B/10B coded before sending.
// - Received symbols are decoded and descrambled onto the parallel outputs.
// - Word starts with 21 or 29 data bits from bit 0 upward.
// - One audio slot bit carries encoded serial data, bit clock, word select.
// - One forward control slot bit carries control data toward the far end.
// - Last bit is parity over the 23 or 31 bits before it.
// - Reverse control and interrupt traffic share the forward twisted pair.
// - Reverse control path never waits on the forward control path.
// - Reverse path stays unusable for 500 us after power-up.
// - Forward link start or stop blanks the reverse path for 350 us.
// - Device addresses reset to 0x80 and 0x90 and are writable.
// - Control channel runs at UART rates from 100 kbps to 1 Mbps.
// - Control channel is selectable as half-duplex or full-duplex.
module slf_word_framer #(
    parameter int unsigned POWERUP_CYCLES = slf_pkg::REV_POWERUP_CYC,
    parameter int unsigned BLANK_CYCLES   = slf_pkg::REV_BLANK_CYC
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             bus_width_select,
    input  wire logic                             audio_enable,
    input  wire logic                             full_duplex_sel,
    input  wire logic [slf_pkg::DATA_PINS-1:0]    data_in,
    input  wire logic                             i2s_sd,
    input  wire logic                             i2s_sck,
    input  wire logic                             i2s_ws,
    input  wire logic                             fwd_ctrl_in,
    input  wire logic                             link_active,
    output logic [slf_pkg::LANES*10-1:0]          tx_symbols,
    output logic                                  tx_valid,
    output logic                                  tx_wide,
    input  wire logic [slf_pkg::LANES*10-1:0]     rx_symbols,
    input  wire logic                             rx_valid,
    output logic [slf_pkg::DATA_PINS-1:0]         data_out,
    output logic                                  i2s_sd_out,
    output logic                                  i2s_sck_out,
    output logic                                  i2s_ws_out,
    output logic                                  fwd_ctrl_out,
    output logic                                  rx_out_valid,
    output logic                                  parity_error,
    output logic                                  code_error,
    input  wire logic                             rev_ctrl_in,
    input  wire logic                             rev_int_in,
    output logic                                  rev_ctrl_out,
    output logic                                  rev_int_out,
    output logic                                  rev_ready,
    output logic                                  host_rx_out,
    input  wire logic                             addr_wr,
    input  wire logic                             addr_sel,
    input  wire logic [7:0]                       addr_wdata,
    output logic [7:0]                            ser_dev_addr,
    output logic [7:0]                            des_dev_addr
);
    import slf_pkg::*;

    // ********************************************************************
    // Line code helpers
    // ********************************************************************
    function automatic logic [10:0] enc8b10b(input logic [7:0] b, input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic       r;
        c6 = SLF_T6[b[4:0]];
        r  = rd;
        if (rd && (($countones(c6) != 3) || (b[4:0] == D6_FLIP))) begin
            c6 = ~c6;
        end
        if ($countones(c6) != 3) begin
            r = ~r;
        end
        c4 = SLF_T4[b[7:5]];
        if (r && (($countones(c4) != 2) || (b[7:5] == D4_FLIP))) begin
            c4 = ~c4;
        end
        if ($countones(c4) != 2) begin
            r = ~r;
        end
        return {r, c6, c4};
    endfunction

    // Complement only matches for codes that really have two forms, so
    // balanced codes cannot alias one another.
    function automatic logic [8:0] dec8b10b(input logic [9:0] s);
        logic [4:0] lo;
        logic [2:0] hi;
        logic       ok6;
        logic       ok4;
        lo  = '0;
        hi  = '0;
        ok6 = 1'b0;
        ok4 = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if ((s[9:4] == SLF_T6[i]) || ((s[9:4] == ~SLF_T6[i]) &&
                (($countones(SLF_T6[i]) != 3) || (i == int'(D6_FLIP))))) begin
                lo  = 5'(i);
                ok6 = 1'b1;
            end
        end
        for (int j = 0; j < 8; j++) begin
            if ((s[3:0] == SLF_T4[j]) || ((s[3:0] == ~SLF_T4[j]) &&
                (($countones(SLF_T4[j]) != 2) || (j == int'(D4_FLIP))))) begin
                hi  = 3'(j);
                ok4 = 1'b1;
            end
        end
        return {~(ok6 & ok4), hi, lo};
    endfunction

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? SCR_POLY : 32'h00000000);
    endfunction

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    logic [SYN_N-1:0] pins_w;
    logic [SYN_N-1:0] sync_a_q;
    logic [SYN_N-1:0] sync_b_q;
    logic             after_rst_q;

    assign pins_w = {full_duplex_sel, rev_int_in, rev_ctrl_in, fwd_ctrl_in,
                     i2s_ws, i2s_sck, i2s_sd, bus_width_select};

    for (genvar p = 0; p < SYN_N; p++) begin : g_sync
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sync_a_q[p] <= 1'b0;
                sync_b_q[p] <= 1'b0;
            end else begin
                sync_a_q[p] <= pins_w[p];
                sync_b_q[p] <= sync_a_q[p];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) after_rst_q <= 1'b0;
        else     after_rst_q <= 1'b1;
    end

    // ********************************************************************
    // Transmit word assembly
    // ********************************************************************
    logic                 wide_w;
    logic [DATA_PINS-1:0] din_w;
    logic                 aud_slot_w;
    logic [WORD_BITS-1:0] word_d;
    logic [WORD_BITS-1:0] word_q;
    logic                 word_wide_q;
    logic                 run_q;
    slf_aud_phase_t       tx_ph_q;
    slf_aud_phase_t       tx_ph_d;

    assign wide_w = sync_b_q[SYN_WID];
    assign din_w  = wide_w ? data_in : {8'h00, data_in[NARROW_DATA-1:0]};

    // Audio pins are framed a sample at a time in a fixed three-word cycle
    always_comb begin
        case (tx_ph_q)
            PH_SD:   aud_slot_w = sync_b_q[SYN_SD];
            PH_SCK:  aud_slot_w = sync_b_q[SYN_SCK];
            PH_WS:   aud_slot_w = sync_b_q[SYN_WS];
            default: aud_slot_w = 1'b0;
        endcase
        if (!audio_enable) begin
            aud_slot_w = sync_b_q[SYN_SD];
        end
        case (tx_ph_q)
            PH_SD:   tx_ph_d = PH_SCK;
            PH_SCK:  tx_ph_d = PH_WS;
            default: tx_ph_d = PH_SD;
        endcase
    end

    logic [WIDE_PAR-1:0] pay_wide_w;
    logic [NARROW_PAR-1:0] pay_narrow_w;

    assign pay_wide_w   = {sync_b_q[SYN_FWD], aud_slot_w, din_w};
    assign pay_narrow_w = {sync_b_q[SYN_FWD], aud_slot_w, din_w[NARROW_DATA-1:0]};
    assign word_d = wide_w ? {^pay_wide_w, pay_wide_w}
                           : {8'h00, ^pay_narrow_w, pay_narrow_w};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_q      <= '0;
            word_wide_q <= 1'b0;
            run_q       <= 1'b0;
            tx_ph_q     <= PH_SD;
        end else begin
            word_q      <= word_d;
            word_wide_q <= wide_w;
            run_q       <= link_active;
            tx_ph_q     <= link_active ? tx_ph_d : PH_SD;
        end
    end

    // ********************************************************************
    // Scramble and line code
    // ********************************************************************
    logic [31:0]               tx_lfsr_q;
    logic [WORD_BITS-1:0]      scr_w;
    logic [LANES:0]            rd_chain;
    logic [10:0]               enc_w [LANES];
    logic [8:0]                dec_w [LANES];
    logic                      rd_q;
    logic [LANES*10-1:0]       sym_w;
    logic [LANES*10-1:0]       tx_sym_q;
    logic                      tx_valid_q;
    logic                      tx_wide_q;

    assign scr_w       = word_q ^ tx_lfsr_q;
    assign rd_chain[0] = rd_q;

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign enc_w[g]      = enc8b10b(scr_w[BYTE_BITS*g +: BYTE_BITS], rd_chain[g]);
        assign rd_chain[g+1] = enc_w[g][10];
        assign sym_w[SYM_BITS*g +: SYM_BITS] = enc_w[g][9:0];
        assign dec_w[g]      = dec8b10b(rx_symbols[SYM_BITS*g +: SYM_BITS]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_lfsr_q  <= SCR_SEED;
            rd_q       <= 1'b0;
            tx_sym_q   <= '0;
            tx_valid_q <= 1'b0;
            tx_wide_q  <= 1'b0;
        end else begin
            tx_lfsr_q  <= run_q ? lfsr_step(tx_lfsr_q) : SCR_SEED;
            rd_q       <= run_q ? (word_wide_q ? rd_chain[4] : rd_chain[3]) : 1'b0;
            tx_sym_q   <= run_q ? (word_wide_q ? sym_w : {10'h000, sym_w[29:0]}) : '0;
            tx_valid_q <= run_q;
            tx_wide_q  <= word_wide_q;
        end
    end

    assign tx_symbols = tx_sym_q;
    assign tx_valid   = tx_valid_q;
    assign tx_wide    = tx_wide_q;

    // ********************************************************************
    // Receive: decode, descramble, unpack
    // ********************************************************************
    logic [31:0]          rx_lfsr_q;
    logic [WORD_BITS-1:0] rx_raw_w;
    logic [WORD_BITS-1:0] rx_word_w;
    logic                 rx_cerr_w;
    logic                 rx_aud_w;
    slf_aud_phase_t       rx_ph_q;
    logic [DATA_PINS-1:0] dout_q;
    logic [2:0]           aud_q;
    logic                 fwd_q;
    logic                 rx_v_q;
    logic                 perr_q;
    logic                 cerr_q;

    assign rx_raw_w  = {dec_w[3][7:0], dec_w[2][7:0], dec_w[1][7:0], dec_w[0][7:0]};
    assign rx_word_w = rx_raw_w ^ rx_lfsr_q;
    assign rx_cerr_w = dec_w[0][8] | dec_w[1][8] | dec_w[2][8] | (wide_w & dec_w[3][8]);
    assign rx_aud_w  = wide_w ? rx_word_w[WIDE_AUD] : rx_word_w[NARROW_AUD];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_lfsr_q <= SCR_SEED;
            rx_ph_q   <= PH_SD;
            dout_q    <= '0;
            aud_q     <= '0;
            fwd_q     <= UART_IDLE;
            rx_v_q    <= 1'b0;
            perr_q    <= 1'b0;
            cerr_q    <= 1'b0;
        end else begin
            rx_v_q <= rx_valid;
            if (rx_valid) begin
                rx_lfsr_q <= lfsr_step(rx_lfsr_q);
                dout_q    <= wide_w ? rx_word_w[DATA_PINS-1:0]
                                    : {8'h00, rx_word_w[NARROW_DATA-1:0]};
                fwd_q     <= wide_w ? rx_word_w[WIDE_FWD] : rx_word_w[NARROW_FWD];
                perr_q    <= wide_w ? ^rx_word_w : ^rx_word_w[NARROW_PAR:0];
                cerr_q    <= rx_cerr_w;
                if (!audio_enable) begin
                    aud_q[0] <= rx_aud_w;
                end else begin
                    aud_q[rx_ph_q] <= rx_aud_w;
                end
                rx_ph_q <= (rx_ph_q == PH_WS) ? PH_SD : slf_aud_phase_t'(rx_ph_q + 2'b01);
            end else begin
                rx_lfsr_q <= SCR_SEED;
                rx_ph_q   <= PH_SD;
            end
        end
    end

    assign data_out     = dout_q;
    assign i2s_sd_out   = aud_q[0];
    assign i2s_sck_out  = aud_q[1];
    assign i2s_ws_out   = aud_q[2];
    assign fwd_ctrl_out = fwd_q;
    assign rx_out_valid = rx_v_q;
    assign parity_error = perr_q;
    assign code_error   = cerr_q;

    // ********************************************************************
    // Reverse control path gating
    // ********************************************************************
    logic [CNT_W-1:0] pwr_cnt_q;
    logic [CNT_W-1:0] blank_q;
    logic             link_q;
    logic             link_edge_w;
    logic             pwr_done_w;
    logic             rctl_q;
    logic             rint_q;
    logic             host_q;

    assign link_edge_w = link_active ^ link_q;
    assign pwr_done_w  = (pwr_cnt_q == CNT_W'(POWERUP_CYCLES));
    // Reverse gating looks only at its own counters, never at forward traffic
    assign rev_ready   = pwr_done_w && (blank_q == '0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_cnt_q <= '0;
            blank_q   <= '0;
            link_q    <= 1'b0;
            rctl_q    <= UART_IDLE;
            rint_q    <= 1'b0;
            host_q    <= UART_IDLE;
        end else begin
            link_q <= link_active;
            if (!pwr_done_w) begin
                pwr_cnt_q <= pwr_cnt_q + 1'b1;
            end
            if (link_edge_w) begin
                blank_q <= CNT_W'(BLANK_CYCLES);
            end else if (blank_q != '0) begin
                blank_q <= blank_q - 1'b1;
            end
            rctl_q <= rev_ready ? sync_b_q[SYN_RCTL] : UART_IDLE;
            rint_q <= rev_ready & sync_b_q[SYN_RINT];
            // Half-duplex shares one host wire, so the host hears its own bits too
            host_q <= sync_b_q[SYN_FDX] ? rctl_q : (rctl_q & sync_b_q[SYN_FWD]);
        end
    end

    assign rev_ctrl_out = rctl_q;
    assign rev_int_out  = rint_q;
    assign host_rx_out  = host_q;

    // ********************************************************************
    // Device address registers
    // ********************************************************************
    logic [7:0] ser_addr_q;
    logic [7:0] des_addr_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_addr_q <= SER_ADDR_RST;
            des_addr_q <= DES_ADDR_RST;
        end else if (addr_wr) begin
            if (addr_sel) des_addr_q <= addr_wdata;
            else          ser_addr_q <= addr_wdata;
        end
    end

    assign ser_dev_addr = ser_addr_q;
    assign des_dev_addr = des_addr_q;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    sequence link_edge_s;
        link_active != link_q;
    endsequence

    sequence blank_hold_s;
        !rev_ready [*8];
    endsequence

    narrow_zero_a: assert property (@(posedge clk) disable iff (rst)
        rx_valid && !wide_w |=> data_out[28:21] == 8'h00)
        else $error("narrow mode upper outputs not low");

    parity_even_a: assert property (@(posedge clk) disable iff (rst)
        after_rst_q |-> ^word_q == 1'b0)
        else $error("link word parity not even");

    data_slot_a: assert property (@(posedge clk) disable iff (rst)
        after_rst_q |-> word_q[20:0] == $past(data_in[20:0]))
        else $error("data bits not at word start");

    fwd_slot_a: assert property (@(posedge clk) disable iff (rst)
        after_rst_q && $past(wide_w) |-> word_q[WIDE_FWD] == $past(sync_b_q[SYN_FWD]))
        else $error("forward control slot wrong");

    sd_extra_a: assert property (@(posedge clk) disable iff (rst)
        after_rst_q && !$past(audio_enable) && !$past(wide_w)
        |-> word_q[NARROW_AUD] == $past(sync_b_q[SYN_SD]))
        else $error("serial data not carried in audio slot");

    powerup_gate_a: assert property (@(posedge clk) disable iff (rst)
        pwr_cnt_q < CNT_W'(POWERUP_CYCLES) |-> !rev_ready)
        else $error("reverse path ready before power-up wait");

    link_blank_a: assert property (@(posedge clk) disable iff (rst)
        link_edge_s |=> blank_hold_s)
        else $error("reverse path not blanked after link edge");

    rev_gate_a: assert property (@(posedge clk) disable iff (rst)
        !rev_ready |=> rev_ctrl_out == UART_IDLE && !rev_int_out)
        else $error("reverse traffic passed while unavailable");

    addr_hold_a: assert property (@(posedge clk) disable iff (rst)
        !addr_wr |=> $stable(ser_dev_addr) && $stable(des_dev_addr))
        else $error("device address changed without write");

    tx_follow_a: assert property (@(posedge clk) disable iff (rst)
        run_q |=> tx_valid && tx_symbols[9:0] == $past(enc_w[0][9:0]))
        else $error("transmit symbols do not follow coded word");

endmodule

/* sim/slf_far_end.sv */
// Far-end model of the paired chip: hands the serial words back to the receiver
module slf_far_end (
    input  wire logic        clk,
    input  wire logic [39:0] tx_symbols,
    input  wire logic        tx_valid,
    output logic [39:0]      rx_symbols,
    output logic             rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle line inverts the last word again every cycle so stale data cannot pass as a match
    always @(posedge clk) begin
        rx_valid <= tx_valid;
        rx_symbols <= tx_valid ? tx_symbols : ~rx_symbols;
    end
endmodule

/* sim/test_slf_word_framer.sv */
// Testbench for the serial link word framer, looped through the far-end model
module test_slf_word_framer;
    timeunit 1ns;
    timeprecision 1ps;
    import slf_pkg::*;
    logic clk = 0, rst = 1, width_sel = 0, aud_en = 1, fdx = 0, sd = 0, sck = 0, ws = 0;
    logic fwd = 1, act = 0, rctl = 1, rint = 0, awr = 0, asel = 0;
    logic [7:0] awd = 8'h00;
    logic [28:0] din = 29'h0;
    logic [39:0] txs, rxs;
    logic txv, rxv, sdo, fco, pe, ce, rco, rio, rdy, hro, scko, wso, txw, rov;
    logic [28:0] dout;
    logic [7:0] sa, da;
    int n_fail = 0, checks_done = 0;
    // Wide mode caps the pixel clock lower, so its half period stretches
    always #(width_sel ? 7 : 5) clk = ~clk;
    slf_word_framer #(.POWERUP_CYCLES(40), .BLANK_CYCLES(12)) dut_u (
        .clk(clk), .rst(rst), .bus_width_select(width_sel), .audio_enable(aud_en),
        .full_duplex_sel(fdx), .data_in(din), .i2s_sd(sd), .i2s_sck(sck), .i2s_ws(ws),
        .fwd_ctrl_in(fwd), .link_active(act), .tx_symbols(txs), .tx_valid(txv),
        .tx_wide(txw), .rx_symbols(rxs), .rx_valid(rxv), .data_out(dout), .i2s_sd_out(sdo),
        .i2s_sck_out(scko), .i2s_ws_out(wso), .fwd_ctrl_out(fco), .rx_out_valid(rov),
        .parity_error(pe), .code_error(ce), .rev_ctrl_in(rctl), .rev_int_in(rint),
        .rev_ctrl_out(rco), .rev_int_out(rio), .rev_ready(rdy), .host_rx_out(hro),
        .addr_wr(awr), .addr_sel(asel), .addr_wdata(awd), .ser_dev_addr(sa), .des_dev_addr(da));
    slf_far_end far_u (.clk(clk), .tx_symbols(txs), .tx_valid(txv), .rx_symbols(rxs),
        .rx_valid(rxv));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_rev_gate;
        chk(sa, 8'h80);
        chk(da, 8'h90);
        cyc(30);
        chk(rdy, 1'b0);
        cyc(15);
        chk(rdy, 1'b1);
        act = 1;
        cyc(2);
        chk(rdy, 1'b0);
        cyc(8);
        chk(rdy, 1'b0);
        cyc(8);
        chk(rdy, 1'b1);
    endtask
    task automatic t_addr(input logic s, input logic [7:0] v);
        asel = s;
        awd = v;
        awr = 1;
        cyc(1);
        awr = 0;
        cyc(1);
        chk(s ? da : sa, v);
    endtask
    // Narrow mode drives all ones so the ignored upper pins must read back low
    task automatic t_loop(input logic w, input logic [28:0] pat);
        width_sel = w;
        din = pat;
        cyc(12);
        chk(dout, w ? pat : (pat & 29'h001FFFFF));
        chk(pe, 1'b0);
        chk(ce, 1'b0);
        chk(txw, w);
        chk(rov, 1'b1);
    endtask
    // Distinct one-hot levels so any swap of the three audio slots shows up
    task automatic t_audio(input logic [2:0] v);
        {sd, sck, ws} = v;
        cyc(12);
        chk({sdo, scko, wso}, v);
    endtask
    task automatic t_side;
        aud_en = 0;
        sd = 1;
        fwd = 0;
        rctl = 0;
        rint = 1;
        cyc(12);
        chk(sdo, 1'b1);
        chk(fco, 1'b0);
        chk(rco, 1'b0);
        chk(rio, 1'b1);
        rctl = 1;
        cyc(8);
        chk(hro, 1'b0);
        fdx = 1;
        cyc(8);
        chk(hro, 1'b1);
        act = 0;
        cyc(5);
        chk(rdy, 1'b0);
        chk(txv, 1'b0);
        chk(rov, 1'b0);
    endtask
    initial begin
        cyc(16);
        rst = 0;
        t_rev_gate();
        t_addr(1'b0, 8'h5A);
        t_addr(1'b1, 8'hA5);
        t_loop(1'b0, 29'h1FFFFFFF);
        t_loop(1'b1, 29'h15A5A5A5);
        t_loop(1'b1, 29'h0A5A5A5A);
        t_audio(3'b010);
        t_audio(3'b001);
        t_side();
        test_done();
    end
    initial begin
        #20us;
        n_fail++;
        test_done();
    end
endmodule
